// ---- src/mcu_alu_pkg.sv ----
package mcu_alu_pkg;
  // ---------------------------------------------------------------
  // operation codes from the decoder
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    add_op, add_carry_op, pair_add_imm_op, subtract_op, subtract_imm_op,
    borrow_subtract_op, borrow_subtract_imm_op, pair_subtract_imm_op,
    and_op, and_imm_op, or_op, inclusive_or_imm_op, xor_registers_op,
    ones_invert_op, twos_complement_op, set_bits_mask_op, clear_bits_mask_op,
    plus_one_op, minus_one_op, zero_minus_test_op,
    product_unsigned_op, product_signed_op, product_mixed_sign_op,
    fractional_product_unsigned_op, fractional_product_signed_op,
    fractional_product_mixed_op,
    relative_jump_op, pointer_jump_op, relative_call_op, pointer_call_op,
    subroutine_exit_op
  } op_e;

  // ---------------------------------------------------------------
  // cycle counts, constants, field positions
  // ---------------------------------------------------------------
  localparam logic [2:0]  CYC_SINGLE = 3'h1;
  localparam logic [2:0]  CYC_WORD   = 3'h2;
  localparam logic [2:0]  CYC_MUL    = 3'h2;
  localparam logic [2:0]  CYC_JUMP   = 3'h2;
  localparam logic [2:0]  CYC_CALL   = 3'h3;
  localparam logic [2:0]  CYC_EXIT   = 3'h4;
  localparam logic [7:0]  BYTE_ONES  = 8'hFF;
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;
  localparam logic [7:0]  BYTE_ONE   = 8'h01;
  localparam logic [7:0]  BYTE_MIN   = 8'h80;
  localparam logic [15:0] PC_RESET   = 16'h0000;
  localparam logic [15:0] PC_STEP    = 16'h0001;
  localparam int          MSB        = 7;
  localparam int          HALF       = 3;
  localparam int          WORD_MSB   = 15;
  localparam int          IMM_W      = 6;
  localparam int          OFF_W      = 12;
  // flag vector positions
  localparam int          F_C        = 0;
  localparam int          F_Z        = 1;
  localparam int          F_N        = 2;
  localparam int          F_V        = 3;
  localparam int          F_S        = 4;
  localparam int          F_H        = 5;
  localparam logic [5:0]  FLAGS_RESET = 6'h00;
  // flag update masks {H,S,V,N,Z,C}
  localparam logic [5:0]  M_ARITH    = 6'h3F;
  localparam logic [5:0]  M_WORD     = 6'h1F;
  localparam logic [5:0]  M_LOGIC    = 6'h1E;
  localparam logic [5:0]  M_MUL      = 6'h03;
  localparam logic [5:0]  M_NONE     = 6'h00;
endpackage : mcu_alu_pkg

// ---- src/mcu_alu_branch_exec.sv ----
`timescale 1ns/1ns
`default_nettype none
module mcu_alu_branch_exec (
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic                opValid,
  input  wire mcu_alu_pkg::op_e    opCode,
  input  wire logic [7:0]          dstVal,
  input  wire logic [7:0]          source_reg,
  input  wire logic [15:0]         pairVal,
  input  wire logic [15:0]         zPtr,
  input  wire logic [11:0]         relOffset,
  input  wire logic [15:0]         stackTop,
  output logic                     ready,
  output logic                     done,
  output logic                     wrByte,
  output logic                     wrPair,
  output logic                     wrProduct,
  output logic [15:0]              wrData,
  output logic [5:0]               statusFlags,
  output logic [15:0]              pc,
  output logic                     stackPush,
  output logic [15:0]              stackData,
  output logic                     stackPop
);
  import mcu_alu_pkg::*;

  // ---------------------------------------------------------------
  // sequencing state and held operands
  // ---------------------------------------------------------------
  typedef enum {IDLE, WAIT} seq_e;
  seq_e        state, next_state;
  logic [2:0]  cnt, next_cnt;
  typedef struct packed {
    op_e         op;
    logic [7:0]  dst, src;
    logic [15:0] pair, ptr, top;
    logic [11:0] off;
  } held_s;
  held_s       held, next_held;
  logic        take, commit;
  // operands seen by the datapath: live when idle, held while waiting
  op_e         curOp;
  logic [7:0]  curDst, curSrc;
  logic [15:0] curPair, curPtr, curTop;
  logic [11:0] curOff;
  // ---------------------------------------------------------------
  // datapath
  // ---------------------------------------------------------------
  logic [7:0]  opA, opB, ar, lr;
  logic        carryIn, useSub;
  logic [8:0]  sum, diff;
  logic        addC, addH, addV, subC, subH, subV;
  logic [15:0] word, aS, bS, prod, cRes, cPc;
  logic [31:0] prod32;
  logic [5:0]  cFlags, cMask;
  logic [2:0]  cCyc;
  logic        cByte, cPair, cProd, cPush, cPop, fz, fn, fv;
  assign take   = opValid && ready;
  assign curOp  = (state == IDLE) ? opCode : held.op;
  assign curDst = (state == IDLE) ? dstVal : held.dst;
  assign curSrc = (state == IDLE) ? source_reg : held.src;
  assign curPair = (state == IDLE) ? pairVal : held.pair;
  assign curPtr = (state == IDLE) ? zPtr : held.ptr;
  assign curTop = (state == IDLE) ? stackTop : held.top;
  assign curOff = (state == IDLE) ? relOffset : held.off;
  // operand selection for the byte adder and subtracter
  always_comb
  begin : operands
    opA     = curDst;
    opB     = curSrc;
    carryIn = 1'b0;
    useSub  = 1'b0;
    unique case (curOp)
      add_carry_op: carryIn = statusFlags[F_C];
      subtract_op, subtract_imm_op: useSub = 1'b1;
      borrow_subtract_op, borrow_subtract_imm_op:
      begin
        useSub  = 1'b1;
        carryIn = statusFlags[F_C];
      end
      twos_complement_op:
      begin
        opA    = BYTE_ZERO;
        opB    = curDst;
        useSub = 1'b1;
      end
      plus_one_op: opB = BYTE_ONE;
      minus_one_op:
      begin
        opB    = BYTE_ONE;
        useSub = 1'b1;
      end
      default: ;
    endcase
  end
  // adder, subtracter and their carry, half carry and overflow
  always_comb
  begin : arith
    sum  = {1'b0, opA} + {1'b0, opB} + {8'h00, carryIn};
    diff = {1'b0, opA} - {1'b0, opB} - {8'h00, carryIn};
    ar   = useSub ? diff[MSB:0] : sum[MSB:0];
    addC = (opA[MSB] & opB[MSB]) | (opB[MSB] & ~ar[MSB]) | (~ar[MSB] & opA[MSB]);
    addH = (opA[HALF] & opB[HALF]) | (opB[HALF] & ~ar[HALF]) | (~ar[HALF] & opA[HALF]);
    addV = (opA[MSB] & opB[MSB] & ~ar[MSB]) | (~opA[MSB] & ~opB[MSB] & ar[MSB]);
    subC = (~opA[MSB] & opB[MSB]) | (opB[MSB] & ar[MSB]) | (ar[MSB] & ~opA[MSB]);
    subH = (~opA[HALF] & opB[HALF]) | (opB[HALF] & ar[HALF]) | (ar[HALF] & ~opA[HALF]);
    subV = (opA[MSB] & ~opB[MSB] & ~ar[MSB]) | (~opA[MSB] & opB[MSB] & ar[MSB]);
  end
  // pair arithmetic and signed or unsigned 8x8 product
  always_comb
  begin : wide
    if (curOp == pair_subtract_imm_op)
      word = curPair - {{(16 - IMM_W){1'b0}}, curSrc[IMM_W-1:0]};
    else
      word = curPair + {{(16 - IMM_W){1'b0}}, curSrc[IMM_W-1:0]};
    aS = {8'h00, curDst};
    bS = {8'h00, curSrc};
    if (curOp inside {product_signed_op, product_mixed_sign_op,
                      fractional_product_signed_op, fractional_product_mixed_op})
      aS = {{8{curDst[MSB]}}, curDst};
    if (curOp inside {product_signed_op, fractional_product_signed_op})
      bS = {{8{curSrc[MSB]}}, curSrc};
    prod32 = aS * bS;
    prod   = prod32[WORD_MSB:0];
  end
  // result, flags, cycle count and program counter per operation
  always_comb
  begin : select
    lr     = BYTE_ZERO;
    cRes   = {8'h00, ar};
    cMask  = M_NONE;
    cCyc   = CYC_SINGLE;
    cByte  = 1'b0;
    cPair  = 1'b0;
    cProd  = 1'b0;
    cPush  = 1'b0;
    cPop   = 1'b0;
    cPc    = pc + PC_STEP;
    fz     = (ar == BYTE_ZERO);
    fn     = ar[MSB];
    fv     = useSub ? subV : addV;
    cFlags = {useSub ? subH : addH, fn ^ fv, fv, fn, fz, useSub ? subC : addC};
    unique case (curOp)
      add_op, add_carry_op, subtract_op, subtract_imm_op, borrow_subtract_op,
      borrow_subtract_imm_op, twos_complement_op:
      begin
        cByte = 1'b1;
        cMask = M_ARITH;
        if (curOp == twos_complement_op)
          cFlags = {ar[HALF] | curDst[HALF], fn ^ (ar == BYTE_MIN),
                    ar == BYTE_MIN, fn, fz, ar != BYTE_ZERO};
      end
      plus_one_op, minus_one_op:
      begin
        cByte = 1'b1;
        cMask = M_LOGIC;
      end
      and_op, and_imm_op, or_op, inclusive_or_imm_op, xor_registers_op,
      ones_invert_op, set_bits_mask_op, clear_bits_mask_op, zero_minus_test_op:
      begin
        unique case (curOp)
          and_op, and_imm_op: lr = curDst & curSrc;
          or_op, inclusive_or_imm_op: lr = curDst | curSrc;
          xor_registers_op: lr = curDst ^ curSrc;
          ones_invert_op: lr = BYTE_ONES - curDst;
          set_bits_mask_op: lr = curDst | curSrc;
          clear_bits_mask_op: lr = curDst & (BYTE_ONES - curSrc);
          default: lr = curDst & curDst;
        endcase
        cRes   = {8'h00, lr};
        cByte  = 1'b1;
        cMask  = (curOp == ones_invert_op) ? M_WORD : M_LOGIC;
        cFlags = {1'b0, lr[MSB], 1'b0, lr[MSB], lr == BYTE_ZERO,
                  curOp == ones_invert_op};
      end
      pair_add_imm_op, pair_subtract_imm_op:
      begin
        cRes  = word;
        cPair = 1'b1;
        cCyc  = CYC_WORD;
        cMask = M_WORD;
        fv    = (curOp == pair_add_imm_op) ? (~curPair[WORD_MSB] & word[WORD_MSB])
                                           : (curPair[WORD_MSB] & ~word[WORD_MSB]);
        cFlags = {1'b0, word[WORD_MSB] ^ fv, fv, word[WORD_MSB], word == 16'h0000,
                  (curOp == pair_add_imm_op) ? (~word[WORD_MSB] & curPair[WORD_MSB])
                                             : (word[WORD_MSB] & ~curPair[WORD_MSB])};
      end
      product_unsigned_op, product_signed_op, product_mixed_sign_op,
      fractional_product_unsigned_op, fractional_product_signed_op,
      fractional_product_mixed_op:
      begin
        cProd = 1'b1;
        cCyc  = CYC_MUL;
        cMask = M_MUL;
        if (curOp inside {product_unsigned_op, product_signed_op, product_mixed_sign_op})
          cRes = prod;
        else
          cRes = {prod[WORD_MSB-1:0], 1'b0};
        cFlags = {4'h0, cRes == 16'h0000, prod[WORD_MSB]};
      end
      relative_jump_op, relative_call_op:
      begin
        cPc   = pc + {{(16 - OFF_W){curOff[OFF_W-1]}}, curOff} + PC_STEP;
        cCyc  = (curOp == relative_call_op) ? CYC_CALL : CYC_JUMP;
        cPush = (curOp == relative_call_op);
      end
      pointer_jump_op:
      begin
        cPc  = curPtr;
        cCyc = CYC_JUMP;
      end
      pointer_call_op:
      begin
        cPc   = curPtr;
        cCyc  = CYC_CALL;
        cPush = 1'b1;
      end
      subroutine_exit_op:
      begin
        cPc  = curTop;
        cCyc = CYC_EXIT;
        cPop = 1'b1;
      end
      default: ;
    endcase
  end
  // ---------------------------------------------------------------
  // sequencer: take, wait out the cycle count, commit
  // ---------------------------------------------------------------
  logic        next_ready, next_done, next_wrByte, next_wrPair, next_wrProduct;
  logic        next_stackPush, next_stackPop;
  logic [15:0] next_wrData, next_pc, next_stackData;
  logic [5:0]  next_statusFlags;
  assign commit = (take && cCyc == CYC_SINGLE) || (state == WAIT && cnt == CYC_SINGLE);
  // next values of sequencing state and outputs
  always_comb
  begin : seq_next
    next_state       = state;
    next_cnt         = cnt;
    next_held        = held;
    next_done        = commit;
    next_wrByte      = commit && cByte;
    next_wrPair      = commit && cPair;
    next_wrProduct   = commit && cProd;
    next_stackPush   = commit && cPush;
    next_stackPop    = commit && cPop;
    next_wrData      = commit ? cRes : wrData;
    next_stackData   = commit ? pc + PC_STEP : stackData;
    next_pc          = commit ? cPc : pc;
    next_statusFlags = commit ? ((statusFlags & ~cMask) | (cFlags & cMask)) : statusFlags;
    if (take && cCyc != CYC_SINGLE)
    begin
      next_state    = WAIT;
      next_cnt      = cCyc - CYC_SINGLE;
      next_held     = {opCode, dstVal, source_reg, pairVal, zPtr, stackTop, relOffset};
    end
    else if (state == WAIT)
    begin
      next_cnt = cnt - CYC_SINGLE;
      if (cnt == CYC_SINGLE)
        next_state = IDLE;
    end
    next_ready = (next_state == IDLE);
  end
  // registers of the sequencer and all outputs
  always_ff @(posedge sys_clk or negedge rst_n)
  begin : seq_regs
    if (!rst_n)
    begin
      state       <= IDLE;
      cnt         <= 3'h0;
      held        <= '0;
      ready       <= 1'b1;
      done        <= 1'b0;
      wrByte      <= 1'b0;
      wrPair      <= 1'b0;
      wrProduct   <= 1'b0;
      stackPush   <= 1'b0;
      stackPop    <= 1'b0;
      wrData      <= 16'h0000;
      stackData   <= 16'h0000;
      pc          <= PC_RESET;
      statusFlags <= FLAGS_RESET;
    end
    else
    begin
      state       <= next_state;
      cnt         <= next_cnt;
      held        <= next_held;
      ready       <= next_ready;
      done        <= next_done;
      wrByte      <= next_wrByte;
      wrPair      <= next_wrPair;
      wrProduct   <= next_wrProduct;
      stackPush   <= next_stackPush;
      stackPop    <= next_stackPop;
      wrData      <= next_wrData;
      stackData   <= next_stackData;
      pc          <= next_pc;
      statusFlags <= next_statusFlags;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  add_one_cycle_a: assert property (take && opCode == add_op |=> done && wrByte
    && wrData[MSB:0] == $past(dstVal) + $past(source_reg)) else $error("add result wrong");
  pair_add_two_a: assert property (take && opCode == pair_add_imm_op |=> !done ##1
    done && wrPair) else $error("pair add timing wrong");
  pair_sub_val_a: assert property (take && opCode == pair_subtract_imm_op ##2 1'b1 |->
    wrData == $past(pairVal, 2) - {10'h000, $past(source_reg[5:0], 2)})
    else $error("pair subtract result wrong");
  sub_value_a: assert property (take && opCode == subtract_op |=>
    wrData[MSB:0] == $past(dstVal) - $past(source_reg)) else $error("subtract wrong");
  and_flags_a: assert property (take && opCode == and_imm_op |=>
    !statusFlags[F_V] && wrData[MSB:0] == ($past(dstVal) & $past(source_reg)))
    else $error("and result wrong");
  invert_carry_a: assert property (take && opCode == ones_invert_op |=>
    statusFlags[F_C] && wrData[MSB:0] == ~$past(dstVal)) else $error("invert wrong");
  mul_two_cyc_a: assert property (take && opCode == product_unsigned_op |=>
    !wrProduct ##1 wrProduct && done) else $error("multiply timing wrong");
  pointer_jump_op_target_a: assert property (take && opCode == pointer_jump_op ##2 1'b1 |->
    pc == $past(zPtr, 2) && done) else $error("pointer jump wrong");
  call_push_a: assert property (take && opCode == pointer_call_op |=> !done [*2] ##1
    stackPush && stackData == $past(pc, 3) + PC_STEP) else $error("call push wrong");
  exit_pop_a: assert property (take && opCode == subroutine_exit_op |->
    ##4 stackPop && done && pc == $past(stackTop, 4)) else $error("exit pop wrong");

  add_seen_c: cover property (take && opCode == add_carry_op ##1 done);
  mul_seen_c: cover property (take && opCode == fractional_product_signed_op ##2 done);
  call_seen_c: cover property (take && opCode == relative_call_op ##3 stackPush);
  exit_seen_c: cover property (take && opCode == subroutine_exit_op ##4 stackPop);
endmodule : mcu_alu_branch_exec
`default_nettype wire

// ---- verification/decoder_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// -------------------------------------------------
// decoder and register file stand-in
// -------------------------------------------------
module decoder_model (
  input  wire logic           sys_clk,
  input  wire logic           ready,
  output var  logic           opValid,
  output var  mcu_alu_pkg::op_e opCode,
  output var  logic [7:0]     dstVal,
  output var  logic [7:0]     sourceReg,
  output var  logic [15:0]    pairVal,
  output var  logic [15:0]    zPtr,
  output var  logic [11:0]    relOffset,
  output var  logic [15:0]    stackTop
);
  import mcu_alu_pkg::*;

  // idle values at time zero
  initial
  begin
    opValid = 1'b0;
    opCode = add_op;
    {dstVal, sourceReg, pairVal, zPtr, relOffset, stackTop} = '0;
  end

  // offer one operation, hold it until taken, then release with inverted operands
  task automatic issue(input op_e op, input logic [7:0] d, s, input logic [15:0] pr, z,
                       input logic [11:0] k, input logic [15:0] top);
    int n = 0;
    @(negedge sys_clk);
    opValid = 1'b1;
    opCode = op;
    {dstVal, sourceReg, pairVal, zPtr, relOffset, stackTop} = {d, s, pr, z, k, top};
    while (ready !== 1'b1 && n < 20)
    begin
      @(negedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    @(negedge sys_clk);
    opValid = 1'b0;
    {dstVal, sourceReg, pairVal, zPtr, relOffset, stackTop} =
      ~{dstVal, sourceReg, pairVal, zPtr, relOffset, stackTop};
  endtask : issue
endmodule : decoder_model
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import mcu_alu_pkg::*;
  localparam logic [4:0] K_BYTE = 5'h10;
  localparam logic [4:0] K_PAIR = 5'h08;
  localparam logic [4:0] K_PROD = 5'h04;
  localparam logic [4:0] K_PUSH = 5'h02;
  localparam logic [4:0] K_POP  = 5'h01;
  localparam logic [4:0] K_NONE = 5'h00;
  logic        sys_clk, rst_n, opValid, ready, done, wrByte, wrPair, wrProduct;
  logic        stackPush, stackPop;
  op_e         opCode;
  logic [7:0]  dstVal, sourceReg;
  logic [11:0] relOffset;
  logic [15:0] pairVal, zPtr, stackTop, wrData, pc, stackData, pcNow;
  logic [5:0]  statusFlags, prevF;
  int          errCount, nCompared;

  // -------------------------------------------------
  // design, partner, clock, watchdog
  // -------------------------------------------------
  mcu_alu_branch_exec dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .opValid(opValid),
    .opCode(opCode), .dstVal(dstVal), .source_reg(sourceReg), .pairVal(pairVal),
    .zPtr(zPtr), .relOffset(relOffset), .stackTop(stackTop), .ready(ready), .done(done),
    .wrByte(wrByte), .wrPair(wrPair), .wrProduct(wrProduct), .wrData(wrData),
    .statusFlags(statusFlags), .pc(pc), .stackPush(stackPush), .stackData(stackData),
    .stackPop(stackPop));
  decoder_model feed_u (.sys_clk(sys_clk), .ready(ready), .opValid(opValid),
    .opCode(opCode), .dstVal(dstVal), .sourceReg(sourceReg), .pairVal(pairVal),
    .zPtr(zPtr), .relOffset(relOffset), .stackTop(stackTop));

  // 40 ns clock
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // cut a hang short
  initial
  begin
    #200000;
    errCount++;
    $display("ERROR watchdog expected finish seen timeout");
    wrapUp();
  end

  // -------------------------------------------------
  // shared tasks
  // -------------------------------------------------
  task automatic cmpVal(input string what, input logic [15:0] expv, seen);
    nCompared++;
    if (seen !== expv)
    begin
      errCount++;
      $display("ERROR %s expected %h seen %h", what, expv, seen);
    end
  endtask : cmpVal

  // run one operation; issue returns one falling edge after the take, where a
  // single-cycle done pulse still stands; ready must stay low until done
  task automatic exec(input op_e op, input logic [7:0] d, s, input logic [15:0] pr, z,
                      input logic [11:0] k, input logic [15:0] top, input int cyc,
                      input logic [4:0] kind);
    int n = 1;
    feed_u.issue(op, d, s, pr, z, k, top);
    while (done !== 1'b1 && n < 8)
    begin
      cmpVal("ready busy", 16'h0000, {15'h0000, ready});
      @(negedge sys_clk);
      n++;
    end
    cmpVal("cycles", 16'(cyc), 16'(n));
    cmpVal("pulses", {11'h000, kind},
           {11'h000, wrByte, wrPair, wrProduct, stackPush, stackPop});
    cmpVal("ready", 16'h0001, {15'h0000, ready});
  endtask : exec

  // data op: result, masked flags with the rest kept, pc plus one
  task automatic alu(input op_e op, input logic [7:0] d, s, input logic [15:0] pr, expD,
                     input logic [5:0] expF, mask, input int cyc, input logic [4:0] kind);
    exec(op, d, s, pr, 16'h0000, 12'h000, 16'h0000, cyc, kind);
    pcNow = pcNow + PC_STEP;
    prevF = (expF & mask) | (prevF & ~mask);
    cmpVal("result", expD, wrData);
    cmpVal("flags", {10'h000, prevF}, {10'h000, statusFlags});
    cmpVal("pc step", pcNow, pc);
  endtask : alu

  task automatic alb(input op_e op, input logic [7:0] d, s, r, input logic [5:0] f, m);
    alu(op, d, s, 16'h0000, {8'h00, r}, f, m, 1, K_BYTE);
  endtask : alb

  // branch op: new pc, return address when pushed, flags untouched
  task automatic br(input op_e op, input logic [15:0] z, input logic [11:0] k,
                    input logic [15:0] top, input int cyc, input logic [4:0] kind);
    logic [15:0] retAddr;
    retAddr = pcNow + PC_STEP;
    exec(op, 8'h00, 8'h00, 16'h0000, z, k, top, cyc, kind);
    case (op)
      relative_jump_op, relative_call_op: pcNow = pcNow + {{4{k[11]}}, k} + PC_STEP;
      pointer_jump_op, pointer_call_op:   pcNow = z;
      default:                            pcNow = top;
    endcase
    cmpVal("branch pc", pcNow, pc);
    cmpVal("flags kept", {10'h000, prevF}, {10'h000, statusFlags});
    if (kind == K_PUSH) cmpVal("return addr", retAddr, stackData);
  endtask : br

  // -------------------------------------------------
  // scenarios
  // -------------------------------------------------
  task automatic testReset();
    @(negedge sys_clk);
    rst_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    cmpVal("reset ready", 16'h0001, {15'h0000, ready});
    cmpVal("reset pc", PC_RESET, pc);
    cmpVal("reset flags", 16'h0000, {10'h000, statusFlags});
    cmpVal("reset out", 16'h0000, wrData | stackData);
    @(negedge sys_clk);
    rst_n = 1'b1;
    pcNow = PC_RESET;
    prevF = FLAGS_RESET;
  endtask : testReset

  task automatic testArith();
    alb(add_op, 8'h8F, 8'h71, 8'h00, 6'h23, M_ARITH);
    alb(add_carry_op, 8'h01, 8'h01, 8'h03, 6'h00, M_ARITH);
    alb(subtract_op, 8'h10, 8'h01, 8'h0F, 6'h20, M_ARITH);
    alb(subtract_imm_op, 8'h80, 8'h01, 8'h7F, 6'h38, M_ARITH);
    alb(subtract_op, 8'h00, 8'h01, 8'hFF, 6'h35, M_ARITH);
    alb(borrow_subtract_op, 8'h05, 8'h02, 8'h02, 6'h00, M_ARITH);
    alb(borrow_subtract_imm_op, 8'h05, 8'h05, 8'h00, 6'h02, M_ARITH);
  endtask : testArith

  task automatic testLogic();
    alb(and_op, 8'hF0, 8'h3C, 8'h30, 6'h00, M_LOGIC);
    alb(and_imm_op, 8'h80, 8'h81, 8'h80, 6'h14, M_LOGIC);
    alb(or_op, 8'h00, 8'h00, 8'h00, 6'h02, M_LOGIC);
    alb(inclusive_or_imm_op, 8'h40, 8'h81, 8'hC1, 6'h14, M_LOGIC);
    alb(xor_registers_op, 8'h55, 8'h55, 8'h00, 6'h02, M_LOGIC);
    alb(ones_invert_op, 8'h0F, 8'h00, 8'hF0, 6'h15, M_WORD);
    alb(twos_complement_op, 8'h01, 8'h00, 8'hFF, 6'h35, M_ARITH);
    alb(twos_complement_op, 8'h80, 8'h00, 8'h80, 6'h0D, M_ARITH);
    alb(set_bits_mask_op, 8'h01, 8'h80, 8'h81, 6'h14, M_LOGIC);
    alb(clear_bits_mask_op, 8'hF0, 8'h30, 8'hC0, 6'h14, M_LOGIC);
    alb(zero_minus_test_op, 8'h00, 8'h5A, 8'h00, 6'h02, M_LOGIC);
    alb(zero_minus_test_op, 8'h80, 8'h00, 8'h80, 6'h14, M_LOGIC);
    alb(plus_one_op, 8'h7F, 8'h00, 8'h80, 6'h0C, M_LOGIC);
    alb(minus_one_op, 8'h80, 8'h00, 8'h7F, 6'h18, M_LOGIC);
  endtask : testLogic

  // immediate is the low six bits of the operand only
  task automatic testPair();
    alu(pair_add_imm_op, 8'h00, 8'h01, 16'hFFFF, 16'h0000, 6'h03, M_WORD, 2, K_PAIR);
    alu(pair_add_imm_op, 8'h00, 8'hFF, 16'h7FFF, 16'h803E, 6'h0C, M_WORD, 2, K_PAIR);
    alu(pair_subtract_imm_op, 8'h00, 8'h01, 16'h0000, 16'hFFFF, 6'h15, M_WORD, 2,
        K_PAIR);
    alu(pair_subtract_imm_op, 8'h00, 8'h3F, 16'h8000, 16'h7FC1, 6'h18, M_WORD, 2,
        K_PAIR);
  endtask : testPair

  task automatic testMul();
    alu(product_unsigned_op, 8'hFF, 8'hFF, 16'h0000, 16'hFE01, 6'h01, M_MUL, 2, K_PROD);
    alu(product_signed_op, 8'hFF, 8'hFF, 16'h0000, 16'h0001, 6'h00, M_MUL, 2, K_PROD);
    alu(product_mixed_sign_op, 8'hFF, 8'h02, 16'h0000, 16'hFFFE, 6'h01, M_MUL, 2, K_PROD);
    alu(product_mixed_sign_op, 8'h02, 8'hFF, 16'h0000, 16'h01FE, 6'h00, M_MUL, 2, K_PROD);
    alu(fractional_product_unsigned_op, 8'hFF, 8'hFF, 16'h0000, 16'hFC02, 6'h01, M_MUL, 2,
        K_PROD);
    alu(fractional_product_signed_op, 8'hFF, 8'h02, 16'h0000, 16'hFFFC, 6'h01, M_MUL, 2,
        K_PROD);
    alu(fractional_product_mixed_op, 8'h80, 8'h80, 16'h0000, 16'h8000, 6'h01, M_MUL, 2,
        K_PROD);
    alu(fractional_product_mixed_op, 8'h00, 8'h55, 16'h0000, 16'h0000, 6'h02, M_MUL, 2,
        K_PROD);
  endtask : testMul

  task automatic testBranch();
    br(relative_jump_op, 16'h0000, 12'hFFF, 16'h0000, 2, K_NONE);
    br(relative_jump_op, 16'h0000, 12'h7FF, 16'h0000, 2, K_NONE);
    br(relative_call_op, 16'h0000, 12'h800, 16'h0000, 3, K_PUSH);
    br(pointer_jump_op, 16'h1234, 12'h000, 16'h0000, 2, K_NONE);
    br(pointer_call_op, 16'hABCD, 12'h000, 16'h0000, 3, K_PUSH);
    br(subroutine_exit_op, 16'h0000, 12'h000, 16'h4321, 4, K_POP);
  endtask : testBranch

  // -------------------------------------------------
  // main sequence and verdict
  // -------------------------------------------------
  task automatic wrapUp();
    $display("compared %0d mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrapUp

  initial
  begin
    rst_n = 1'b0;
    errCount = 0;
    nCompared = 0;
    testReset();
    testArith();
    testLogic();
    testPair();
    testMul();
    testBranch();
    testReset();
    alb(add_op, 8'h7F, 8'h01, 8'h80, 6'h2C, M_ARITH);
    wrapUp();
  end
endmodule : testbench
`default_nettype wire
